// ===== dv/dclr_i2c_master.sv
`timescale 1ns/10ps
// bus master model; clock stands high between frames
module dclr_i2c_master (
	input  wire logic clk_in,
	input  wire logic sda_in,
	output logic      scl_out,
	output logic      sda_out
);
	// released lines rest high on the pull-up
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	// quarter bit of 625 ns keeps the clock at 400 kHz
	task q;
		repeat (25) @(posedge clk_in);
	endtask
	// start, also usable as repeated start
	task start;
		sda_out <= 1'b1;
		q;
		scl_out <= 1'b1;
		q;
		sda_out <= 1'b0;
		q;
		scl_out <= 1'b0;
		q;
	endtask
	task stop;
		sda_out <= 1'b0;
		q;
		scl_out <= 1'b1;
		q;
		sda_out <= 1'b1;
		q;
	endtask
	// data moves only while the clock is low
	task bit_io(input logic b, output logic r);
		sda_out <= b;
		q;
		scl_out <= 1'b1;
		q;
		r = sda_in;
		q;
		scl_out <= 1'b0;
		q;
	endtask
	task wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, r);
		ack = ~r;
	endtask
	// nack on the last byte ends a burst
	task rbyte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(last, r);
	endtask
endmodule

// ===== dv/dclr_top_bench.sv
`timescale 1ns/10ps
module dclr_top_bench;
	import dclr_pkg::*;
	localparam int UC = 20; // short unit for simulation
	localparam int PC = 4;
	logic        clk_sys_in = 1'b0;
	logic        clk_link   = 1'b0;
	logic        resetn     = 1'b0;
	logic        addr_sel   = 1'b0;
	logic [15:0] ch0        = 16'h0000;
	logic [15:0] ch1        = 16'h0000;
	logic        scl, sda_m, sda_o, sda_oe, st, act, irq;
	logic [7:0]  rb [4];
	int          fails = 0;
	int          checks = 0;
	int          n;
	// open drain wire: low if any party pulls
	wire sda_w = sda_m & ~(sda_oe & ~sda_o);
	always #12.5 clk_sys_in = ~clk_sys_in;
	// 80 ns link clock; its edges never meet the system clock rising edges
	always #40 clk_link = ~clk_link;
	dclr_top #(.UNIT_CYCLES(UC), .PULSE_CYCLES(PC),
		.ID_LO(8'h3C), .ID_HI(8'hC3)) u_dclr_top ( // arbitrary ids
		.clk_sys_in(clk_sys_in), .resetn_in(resetn),
		.clk_link_in(clk_link), .scl_in(scl), .sda_in(sda_w),
		.sda_out(sda_o), .sda_oe_out(sda_oe), .addr_sel_in(addr_sel),
		.ch0_count_in(ch0), .ch1_count_in(ch1),
		.integ_start_out(st), .integ_active_out(act), .int_out(irq));
	dclr_i2c_master u_dclr_i2c_master (.clk_in(clk_sys_in),
		.sda_in(sda_w), .scl_out(scl), .sda_out(sda_m));
	task chk(input logic [15:0] s, input logic [15:0] e);
		checks++;
		if (s !== e) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task results;
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// register write, one byte or a two byte burst
	task wr(input logic [7:0] r, input logic [15:0] d, input int k);
		logic a;
		u_dclr_i2c_master.start;
		u_dclr_i2c_master.wbyte({DCLR_ADDR_LOW, 1'b0}, a);
		chk(16'(a), 16'h0001);
		u_dclr_i2c_master.wbyte(r, a);
		for (int i = 0; i < k; i++) begin
			u_dclr_i2c_master.wbyte(d[8*i+:8], a);
		end
		u_dclr_i2c_master.stop;
	endtask
	// pointer write, repeated start, burst read
	task rd(input logic [7:0] r, input int k);
		logic a;
		u_dclr_i2c_master.start;
		u_dclr_i2c_master.wbyte({DCLR_ADDR_LOW, 1'b0}, a);
		u_dclr_i2c_master.wbyte(r, a);
		u_dclr_i2c_master.start;
		u_dclr_i2c_master.wbyte({DCLR_ADDR_LOW, 1'b1}, a);
		chk(16'(a), 16'h0001);
		for (int i = 0; i < k; i++) begin
			u_dclr_i2c_master.rbyte(i == k - 1, rb[i]);
		end
		u_dclr_i2c_master.stop;
	endtask
	// cycles between two start pulses, bounded
	task gap(output int g);
		int i;
		i = 0;
		while (st !== 1'b1 && i < 500) begin
			@(posedge clk_sys_in);
			i++;
		end
		@(posedge clk_sys_in);
		g = 1;
		while (st !== 1'b1 && g < 500) begin
			@(posedge clk_sys_in);
			g++;
		end
		if (i >= 500 || g >= 500) begin
			fails++;
			results;
		end
	endtask
	task wait_int;
		int i;
		i = 0;
		while (irq !== 1'b1 && i < 300) begin
			@(posedge clk_sys_in);
			i++;
		end
		if (i >= 300) begin
			fails++;
			results;
		end
	endtask
	task t_conv;
		ch0 <= 16'h2468;
		ch1 <= 16'h1357;
		gap(n);
		chk(16'(n), 16'(UC));
		chk(16'(act), 16'h0001);
	endtask
	// both results in one burst, then the id bytes
	task t_regs;
		rd(DCLR_REG_D0_LO, 4);
		chk({rb[1], rb[0]}, 16'h2468);
		chk({rb[3], rb[2]}, 16'h1357);
		rd(DCLR_REG_ID_LO, 2);
		chk({rb[1], rb[0]}, 16'hC33C);
	endtask
	// each pin level against both addresses
	task t_addr;
		logic a;
		for (int s = 0; s < 2; s++) begin
			addr_sel <= s[0];
			repeat (20) @(posedge clk_sys_in);
			for (int k = 0; k < 2; k++) begin
				u_dclr_i2c_master.start;
				u_dclr_i2c_master.wbyte({6'h08, k[0], 1'b0}, a);
				u_dclr_i2c_master.stop;
				chk(16'(a), 16'(s == k));
			end
		end
		addr_sel <= 1'b0;
	endtask
	task t_itime;
		wr(DCLR_REG_ITIME, 16'h0002, 1);
		gap(n);
		gap(n);
		chk(16'(n), 16'(2 * UC));
		wr(DCLR_REG_ITIME, 16'h0001, 1);
	endtask
	// level: held past in-window results; pulse: PC cycles wide
	task t_int;
		wr(DCLR_REG_THH_LO, 16'h1000, 2);
		wr(DCLR_REG_CTRL, 16'h0003, 1);
		ch0 <= 16'h2000;
		wait_int;
		ch0 <= 16'h1000;
		repeat (100) @(posedge clk_sys_in);
		chk(16'(irq), 16'h0001);
		wr(DCLR_REG_STAT, 16'h0001, 1);
		repeat (100) @(posedge clk_sys_in);
		chk(16'(irq), 16'h0000);
		wr(DCLR_REG_THL_LO, 16'h0100, 2);
		wr(DCLR_REG_CTRL, 16'h0007, 1);
		ch0 <= 16'h0010;
		wait_int;
		n = 0;
		while (irq === 1'b1 && n < 50) begin
			@(posedge clk_sys_in);
			n++;
		end
		chk(16'(n), 16'(PC));
	endtask
	initial begin
		repeat (10) @(posedge clk_sys_in);
		resetn <= 1'b1;
		repeat (40) @(posedge clk_sys_in);
		t_conv;
		t_regs;
		t_addr;
		t_itime;
		t_int;
		results;
	end
endmodule

// ===== hdl/dclr_pkg.sv
package dclr_pkg;

	// slave addresses picked by the address-select pin
	localparam logic [6:0] DCLR_ADDR_LOW  = 7'h10;
	localparam logic [6:0] DCLR_ADDR_HIGH = 7'h11;

	// byte offsets of the register map
	localparam logic [7:0] DCLR_REG_ID_LO  = 8'h00;
	localparam logic [7:0] DCLR_REG_ID_HI  = 8'h01;
	localparam logic [7:0] DCLR_REG_CTRL   = 8'h03;
	localparam logic [7:0] DCLR_REG_ITIME  = 8'h04;
	localparam logic [7:0] DCLR_REG_THL_LO = 8'h05;
	localparam logic [7:0] DCLR_REG_THL_HI = 8'h06;
	localparam logic [7:0] DCLR_REG_THH_LO = 8'h07;
	localparam logic [7:0] DCLR_REG_THH_HI = 8'h08;
	localparam logic [7:0] DCLR_REG_D0_LO  = 8'h09;
	localparam logic [7:0] DCLR_REG_D0_HI  = 8'h0A;
	localparam logic [7:0] DCLR_REG_D1_LO  = 8'h0B;
	localparam logic [7:0] DCLR_REG_D1_HI  = 8'h0C;
	localparam logic [7:0] DCLR_REG_STAT   = 8'h0D;

	// field positions
	localparam int DCLR_CTRL_EN_BIT    = 0;
	localparam int DCLR_CTRL_INTEN_BIT = 1;
	localparam int DCLR_CTRL_PULSE_BIT = 2;
	localparam int DCLR_STAT_INT_BIT   = 0;
	localparam int DCLR_STAT_NEW_BIT   = 1;

	// result width of each channel
	localparam int DCLR_RES_W = 16;

	// reset values
	localparam logic [7:0]  DCLR_ITIME_RST = 8'h01;
	localparam logic [15:0] DCLR_THL_RST   = 16'h0000;
	localparam logic [15:0] DCLR_THH_RST   = 16'hFFFF;

	// timing
	localparam real DCLR_UNIT_TIME_MS   = 2.7;
	localparam real DCLR_SYS_CLK_MHZ    = 40.0;
	localparam int  DCLR_UNIT_CYCLES    =
		int'(DCLR_UNIT_TIME_MS * 1000.0 * DCLR_SYS_CLK_MHZ);
	localparam int  DCLR_PULSE_TIME_NS  = 1000;
	localparam int  DCLR_SYS_CLK_KHZ    = 40000;
	localparam int  DCLR_PULSE_CYCLES   =
		(DCLR_PULSE_TIME_NS * DCLR_SYS_CLK_KHZ + 999999) / 1000000;
	localparam int  DCLR_I2C_FMAX_KHZ   = 400;
	localparam int  DCLR_OVERSAMPLE_MIN = 8;

	// configuration word passed from the link side to the converter side
	typedef struct packed {
		logic        en;
		logic        inten;
		logic        pulse;
		logic [7:0]  itime;
		logic [15:0] thh;
		logic [15:0] thl;
		logic        clr;
	} dclr_cfg_t;

	localparam dclr_cfg_t DCLR_CFG_RST = '{
		en: 1'b1, inten: 1'b0, pulse: 1'b0, itime: DCLR_ITIME_RST,
		thh: DCLR_THH_RST, thl: DCLR_THL_RST, clr: 1'b0};

	// converter side states
	typedef enum logic [1:0] {
		DCLR_S_OFF   = 2'b00,
		DCLR_S_INTEG = 2'b01
	} dclr_sys_st_t;

	// serial slave states
	typedef enum logic [3:0] {
		DCLR_L_IDLE = 4'b0000,
		DCLR_L_ADDR = 4'b0001,
		DCLR_L_AACK = 4'b0010,
		DCLR_L_REG  = 4'b0011,
		DCLR_L_RACK = 4'b0100,
		DCLR_L_WR   = 4'b0101,
		DCLR_L_WACK = 4'b0110,
		DCLR_L_RD   = 4'b0111,
		DCLR_L_MACK = 4'b1000
	} dclr_lnk_st_t;

endpackage

// ===== hdl/dclr_sync.sv
`timescale 1ns/10ps
// two-flop level synchroniser, one bit per lane
module dclr_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_in,
	input  wire logic         rstn_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	typedef struct packed {
		logic [W-1:0] s1;	// metastable stage, read only by s2
		logic [W-1:0] s2;	// settled stage
	} dclr_sync_t;

	dclr_sync_t s;
	dclr_sync_t next_s;

	// plain shift through both stages
	always_comb begin
		next_s    = s;
		next_s.s1 = d_in;
		next_s.s2 = s.s1;
	end

	// synchronous reset to zero
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign q_out = s.s2;
endmodule

// ===== hdl/dclr_top.sv
`timescale 1ns/10ps
module dclr_top
	import dclr_pkg::*;
#(
	parameter int         UNIT_CYCLES  = DCLR_UNIT_CYCLES,
	parameter int         PULSE_CYCLES = DCLR_PULSE_CYCLES,
	parameter int         LINK_CLK_KHZ = 12500,
	parameter logic [7:0] ID_LO        = 8'h5A,	// arbitrary value
	parameter logic [7:0] ID_HI        = 8'hA5	// arbitrary value
) (
	input  wire logic                  clk_sys_in,
	input  wire logic                  resetn_in,
	input  wire logic                  clk_link_in,
	input  wire logic                  scl_in,
	input  wire logic                  sda_in,
	output logic                       sda_out,
	output logic                       sda_oe_out,
	input  wire logic                  addr_sel_in,
	input  wire logic [DCLR_RES_W-1:0] ch0_count_in,
	input  wire logic [DCLR_RES_W-1:0] ch1_count_in,
	output logic                       integ_start_out,
	output logic                       integ_active_out,
	output logic                       int_out
);
	localparam int RW2 = 2 * DCLR_RES_W;

	// refuse settings the counters cannot hold
	if (UNIT_CYCLES < 1) begin : g_chk_unit
		$error("unit period must be at least one cycle");
	end
	if (PULSE_CYCLES < 4 || PULSE_CYCLES > 65535) begin : g_chk_pulse
		$error("pulse length outside 4..65535");
	end
	// link clock must oversample the fastest serial clock
	if (LINK_CLK_KHZ < DCLR_OVERSAMPLE_MIN * DCLR_I2C_FMAX_KHZ) begin : g_chk
		$error("link clock too slow for fast mode");
	end

	// converter side state
	typedef struct packed {
		dclr_sys_st_t st;	// off or integrating
		logic [31:0]  ucnt;	// cycles within one unit
		logic [7:0]   mcnt;	// units elapsed
		logic [7:0]   units;	// units for this cycle
		logic [15:0]  res0;	// channel 0 data
		logic [15:0]  res1;	// channel 1 data
		logic         start_o;	// integration start pulse
		logic         flag;	// held interrupt
		logic [15:0]  pcnt;	// pulse cycles left
		logic         int_o;	// interrupt pin
		logic         clr_q;	// last clear toggle
	} sys_t;

	// link side state
	typedef struct packed {
		dclr_lnk_st_t st;	// serial slave state
		logic [3:0]   bitc;	// bits in current byte
		logic [7:0]   sh;	// shift register
		logic [7:0]   ptr;	// register pointer
		logic         rw;	// transfer is a read
		logic         nack;	// master refused the byte
		logic         oe;	// pulling sda low
		logic         scl_q;	// previous scl
		logic         sda_q;	// previous sda
		dclr_cfg_t    cfg;	// host settings
		logic [31:0]  res;	// latest results as crossed
		logic [31:0]  snap;	// results frozen for a read
		logic         newd;	// fresh results arrived
		logic         load;	// settings changed pulse
	} lnk_t;

	sys_t            s;
	sys_t            next_s;
	lnk_t            l;
	lnk_t            next_l;
	logic            lrstn;	// reset in the link domain
	dclr_cfg_t       cfg_s;	// settings seen by the converter
	logic            conv_end;	// last cycle of an integration
	logic            hit;	// result outside the window
	logic            clr_ev;	// host cleared the interrupt
	logic [RW2-1:0]  res_l;	// results seen by the link
	logic            res_stb;	// new results in link domain
	logic [3:0]      pins;	// synced addr, scl, sda, flag
	logic            addr_s;
	logic            scl_s;
	logic            sda_s;
	logic            flag_s;
	logic            start_ev;
	logic            stop_ev;
	logic            rise;
	logic            fall;
	logic [6:0]      my_addr;
	logic [7:0]      rd_now;	// byte at pointer

	// converter: fixed unit period, both channels share one start
	always_comb begin
		next_s         = s;
		next_s.start_o = 1'b0;
		next_s.clr_q   = cfg_s.clr;
		clr_ev         = cfg_s.clr != s.clr_q;
		conv_end       = 1'b0;
		case (s.st)
			DCLR_S_OFF: begin
				if (cfg_s.en) begin
					next_s.st      = DCLR_S_INTEG;
					next_s.start_o = 1'b1;
					next_s.ucnt    = '0;
					next_s.mcnt    = '0;
					next_s.units   = (cfg_s.itime == 8'h00) ?
						8'h01 : cfg_s.itime;
				end
			end
			DCLR_S_INTEG: begin
				if (!cfg_s.en) begin
					next_s.st = DCLR_S_OFF;	// drop the running cycle
				end else if (s.ucnt == 32'(UNIT_CYCLES - 1)) begin
					next_s.ucnt = '0;
					if (s.mcnt == s.units - 8'h01) begin
						conv_end       = 1'b1;
						next_s.res0    = ch0_count_in;
						next_s.res1    = ch1_count_in;
						next_s.start_o = 1'b1;
						next_s.mcnt    = '0;
						next_s.units   = (cfg_s.itime == 8'h00) ?
							8'h01 : cfg_s.itime;
					end else begin
						next_s.mcnt = s.mcnt + 8'h01;
					end
				end else begin
					next_s.ucnt = s.ucnt + 32'h0000_0001;
				end
			end
			default: begin
				next_s.st = DCLR_S_OFF;
			end
		endcase
		// compare channel 0 only at the latch moment
		hit = conv_end && cfg_s.inten &&
			(ch0_count_in > cfg_s.thh ||
			ch0_count_in < cfg_s.thl);
		if (clr_ev) begin
			next_s.flag = 1'b0;
		end
		if (hit && !cfg_s.pulse) begin
			next_s.flag = 1'b1;	// set wins over clear
		end
		if (s.pcnt != 16'h0000) begin
			next_s.pcnt = s.pcnt - 16'h0001;
		end
		if (hit && cfg_s.pulse) begin
			next_s.pcnt = 16'(PULSE_CYCLES);
		end
		next_s.int_o = next_s.flag || (next_s.pcnt != 16'h0000);
	end

	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign integ_start_out  = s.start_o;
	assign integ_active_out = s.st == DCLR_S_INTEG;
	assign int_out          = s.int_o;

	// helper: cycles since the last start, for the period check;
	// at the end cycle it is one short, the restart cycle completes it
	int unsigned gap;
	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in || s.start_o) begin
			gap <= 1;
		end else begin
			gap <= gap + 1;
		end
	end

	a_period_len: assert property (@(posedge clk_sys_in)
		disable iff (!resetn_in)
		conv_end |-> gap + 1 == int'(s.units) * UNIT_CYCLES)
		else $error("integration period wrong");
	a_latch_restart: assert property (@(posedge clk_sys_in)
		disable iff (!resetn_in)
		conv_end |=> integ_start_out ##1 !integ_start_out)
		else $error("no restart after latch");
	a_latch_both: assert property (@(posedge clk_sys_in)
		disable iff (!resetn_in)
		conv_end |=> s.res0 == $past(ch0_count_in) &&
			s.res1 == $past(ch1_count_in))
		else $error("results not latched");
	a_int_level: assert property (@(posedge clk_sys_in)
		disable iff (!resetn_in)
		conv_end && cfg_s.inten && !cfg_s.pulse && !clr_ev &&
		ch0_count_in > cfg_s.thh |=> int_out)
		else $error("missed upper limit interrupt");
	a_int_pulse: assert property (@(posedge clk_sys_in)
		disable iff (!resetn_in)
		conv_end && cfg_s.inten && cfg_s.pulse &&
		ch0_count_in < cfg_s.thl && !s.flag |=> int_out[*4])
		else $error("pulse interrupt too short");
	a_cmp_latched: assert property (@(posedge clk_sys_in)
		disable iff (!resetn_in)
		$rose(s.flag) |-> $past(conv_end))
		else $error("compare outside latch");

	// settings cross from link to converter side
	dclr_xfer #(.W($bits(dclr_cfg_t)), .INIT(DCLR_CFG_RST)) u_cfgx (
		.clk_a_in   (clk_link_in),
		.rstn_a_in  (lrstn),
		.load_a_in  (l.load),
		.data_a_in  (l.cfg),
		.clk_b_in   (clk_sys_in),
		.rstn_b_in  (resetn_in),
		.data_b_out (cfg_s),
		.stb_b_out  ()
	);

	// both results cross as one word
	dclr_xfer #(.W(RW2)) u_resx (
		.clk_a_in   (clk_sys_in),
		.rstn_a_in  (resetn_in),
		.load_a_in  (conv_end),
		.data_a_in  ({ch1_count_in, ch0_count_in}),
		.clk_b_in   (clk_link_in),
		.rstn_b_in  (lrstn),
		.data_b_out (res_l),
		.stb_b_out  (res_stb)
	);

	// reset into the link domain
	dclr_sync #(.W(1)) u_rsync (
		.clk_in  (clk_link_in),
		.rstn_in (1'b1),
		.d_in    (resetn_in),
		.q_out   (lrstn)
	);

	// pins and the interrupt level into the link domain
	dclr_sync #(.W(4)) u_psync (
		.clk_in  (clk_link_in),
		.rstn_in (lrstn),
		.d_in    ({addr_sel_in, scl_in, sda_in, s.flag}),
		.q_out   (pins)
	);
	assign {addr_s, scl_s, sda_s, flag_s} = pins;

	// register read mux; unmapped offsets read zero
	function automatic logic [7:0] rd_byte(input logic [7:0] a,
		input lnk_t x, input logic f);
		logic [7:0] b;
		b = 8'h00;
		if (a == DCLR_REG_ID_LO) begin
			b = ID_LO;
		end else if (a == DCLR_REG_ID_HI) begin
			b = ID_HI;
		end else if (a == DCLR_REG_CTRL) begin
			b[DCLR_CTRL_EN_BIT]    = x.cfg.en;
			b[DCLR_CTRL_INTEN_BIT] = x.cfg.inten;
			b[DCLR_CTRL_PULSE_BIT] = x.cfg.pulse;
		end else if (a == DCLR_REG_ITIME) begin
			b = x.cfg.itime;
		end else if (a == DCLR_REG_THL_LO) begin
			b = x.cfg.thl[7:0];
		end else if (a == DCLR_REG_THL_HI) begin
			b = x.cfg.thl[15:8];
		end else if (a == DCLR_REG_THH_LO) begin
			b = x.cfg.thh[7:0];
		end else if (a == DCLR_REG_THH_HI) begin
			b = x.cfg.thh[15:8];
		end else if (a == DCLR_REG_D0_LO) begin
			b = x.snap[7:0];
		end else if (a == DCLR_REG_D0_HI) begin
			b = x.snap[15:8];
		end else if (a == DCLR_REG_D1_LO) begin
			b = x.snap[23:16];
		end else if (a == DCLR_REG_D1_HI) begin
			b = x.snap[31:24];
		end else if (a == DCLR_REG_STAT) begin
			b[DCLR_STAT_INT_BIT] = f;
			b[DCLR_STAT_NEW_BIT] = x.newd;
		end
		return b;
	endfunction

	// serial slave, oversampled on the link clock
	always_comb begin
		next_l       = l;
		next_l.scl_q = scl_s;
		next_l.sda_q = sda_s;
		next_l.load  = 1'b0;
		start_ev = scl_s && l.scl_q && l.sda_q && !sda_s;
		stop_ev  = scl_s && l.scl_q && !l.sda_q && sda_s;
		rise     = scl_s && !l.scl_q;
		fall     = !scl_s && l.scl_q;
		my_addr  = addr_s ? DCLR_ADDR_HIGH : DCLR_ADDR_LOW;
		rd_now   = rd_byte(l.ptr, l, flag_s);
		if (start_ev) begin
			next_l.st   = DCLR_L_ADDR;	// also repeated start
			next_l.bitc = '0;
			next_l.oe   = 1'b0;
		end else if (stop_ev) begin
			next_l.st = DCLR_L_IDLE;
			next_l.oe = 1'b0;
		end else if (rise) begin
			if ((l.st == DCLR_L_ADDR || l.st == DCLR_L_REG ||
				l.st == DCLR_L_WR) && l.bitc != 4'h8) begin
				next_l.sh   = {l.sh[6:0], sda_s};
				next_l.bitc = l.bitc + 4'h1;
			end else if (l.st == DCLR_L_MACK) begin
				next_l.nack = sda_s;
			end
		end else if (fall) begin
			case (l.st)
				DCLR_L_ADDR: begin
					if (l.bitc == 4'h8) begin
						if (l.sh[7:1] == my_addr) begin
							next_l.oe = 1'b1;
							next_l.rw = l.sh[0];
							next_l.st = DCLR_L_AACK;
							if (l.sh[0]) begin
								next_l.snap = l.res;
							end
						end else begin
							next_l.st = DCLR_L_IDLE;
						end
					end
				end
				DCLR_L_AACK: begin
					next_l.bitc = '0;
					if (l.rw) begin
						next_l.st   = DCLR_L_RD;
						next_l.sh   = rd_now;
						next_l.oe   = ~rd_now[7];
						next_l.bitc = 4'h1;
						if (l.ptr == DCLR_REG_STAT) begin
							next_l.newd = 1'b0;
						end
					end else begin
						next_l.st = DCLR_L_REG;
						next_l.oe = 1'b0;
					end
				end
				DCLR_L_REG: begin
					if (l.bitc == 4'h8) begin
						next_l.ptr = l.sh;
						next_l.oe  = 1'b1;
						next_l.st  = DCLR_L_RACK;
					end
				end
				DCLR_L_RACK, DCLR_L_WACK: begin
					next_l.oe   = 1'b0;
					next_l.bitc = '0;
					next_l.st   = DCLR_L_WR;
				end
				DCLR_L_WR: begin
					if (l.bitc == 4'h8) begin
						next_l.ptr  = l.ptr + 8'h01;
						next_l.oe   = 1'b1;
						next_l.st   = DCLR_L_WACK;
						next_l.load = 1'b1;
						if (l.ptr == DCLR_REG_CTRL) begin
							next_l.cfg.en    = l.sh[DCLR_CTRL_EN_BIT];
							next_l.cfg.inten = l.sh[DCLR_CTRL_INTEN_BIT];
							next_l.cfg.pulse = l.sh[DCLR_CTRL_PULSE_BIT];
						end else if (l.ptr == DCLR_REG_ITIME) begin
							next_l.cfg.itime = l.sh;
						end else if (l.ptr == DCLR_REG_THL_LO) begin
							next_l.cfg.thl[7:0] = l.sh;
						end else if (l.ptr == DCLR_REG_THL_HI) begin
							next_l.cfg.thl[15:8] = l.sh;
						end else if (l.ptr == DCLR_REG_THH_LO) begin
							next_l.cfg.thh[7:0] = l.sh;
						end else if (l.ptr == DCLR_REG_THH_HI) begin
							next_l.cfg.thh[15:8] = l.sh;
						end else if (l.ptr == DCLR_REG_STAT) begin
							if (l.sh[DCLR_STAT_INT_BIT]) begin
								next_l.cfg.clr = ~l.cfg.clr;
							end
						end
					end
				end
				DCLR_L_RD: begin
					if (l.bitc == 4'h8) begin
						next_l.oe  = 1'b0;	// master drives its ack
						next_l.st  = DCLR_L_MACK;
						next_l.ptr = l.ptr + 8'h01;
					end else begin
						next_l.oe   = ~l.sh[6];
						next_l.sh   = {l.sh[6:0], 1'b0};
						next_l.bitc = l.bitc + 4'h1;
					end
				end
				DCLR_L_MACK: begin
					if (l.nack) begin
						next_l.st = DCLR_L_IDLE;
					end else begin
						next_l.st   = DCLR_L_RD;
						next_l.sh   = rd_now;
						next_l.oe   = ~rd_now[7];
						next_l.bitc = 4'h1;
						if (l.ptr == DCLR_REG_STAT) begin
							next_l.newd = 1'b0;
						end
					end
				end
				default: begin
					next_l.oe = 1'b0;
				end
			endcase
		end
		// fresh results, set wins over the read clear
		if (res_stb) begin
			next_l.res  = res_l;
			next_l.newd = 1'b1;
		end
	end

	always_ff @(posedge clk_link_in) begin
		if (!lrstn) begin
			l <= '{st: DCLR_L_IDLE, scl_q: 1'b1, sda_q: 1'b1,
				cfg: DCLR_CFG_RST, default: '0};
		end else begin
			l <= next_l;
		end
	end

	assign sda_out    = 1'b0;	// open drain, only ever pulls low
	assign sda_oe_out = l.oe;

	a_addr_ack: assert property (@(posedge clk_link_in)
		disable iff (!lrstn)
		fall && l.st == DCLR_L_ADDR && l.bitc == 4'h8 &&
		l.sh[7:1] == my_addr |=> sda_oe_out)
		else $error("own address not acknowledged");
	a_addr_foreign: assert property (@(posedge clk_link_in)
		disable iff (!lrstn)
		fall && l.st == DCLR_L_ADDR && l.bitc == 4'h8 &&
		l.sh[7:1] != my_addr |=> !sda_oe_out && l.st == DCLR_L_IDLE)
		else $error("foreign address answered");
	a_ptr_step: assert property (@(posedge clk_link_in)
		disable iff (!lrstn)
		fall && (l.st == DCLR_L_WR || l.st == DCLR_L_RD) &&
		l.bitc == 4'h8 |=> l.ptr == $past(l.ptr) + 8'h01)
		else $error("pointer did not step");
endmodule

// ===== hdl/dclr_xfer.sv
`timescale 1ns/10ps
// word crossing by toggle: the held word stays still until the toggle
// has been seen, so loads must be spaced wider than the sync latency
module dclr_xfer #(
	parameter int           W    = 8,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         clk_a_in,
	input  wire logic         rstn_a_in,
	input  wire logic         load_a_in,
	input  wire logic [W-1:0] data_a_in,
	input  wire logic         clk_b_in,
	input  wire logic         rstn_b_in,
	output logic      [W-1:0] data_b_out,
	output logic              stb_b_out
);
	// one struct per clock domain; the receiver reads the sender's held word directly
	typedef struct packed {
		logic         tgl;	// flips on each load
		logic [W-1:0] hold;	// word held for the far side
	} dclr_xa_t;

	typedef struct packed {
		logic         tq;	// last toggle seen
		logic [W-1:0] data;	// copied word
		logic         stb;	// one-cycle new word pulse
	} dclr_xb_t;

	dclr_xa_t a;
	dclr_xa_t next_a;
	dclr_xb_t b;
	dclr_xb_t next_b;
	logic     tgl_b;	// toggle after synchroniser

	// sender: capture word and flip toggle
	always_comb begin
		next_a = a;
		if (load_a_in) begin
			next_a.hold = data_a_in;
			next_a.tgl  = ~a.tgl;
		end
	end

	always_ff @(posedge clk_a_in) begin
		if (!rstn_a_in) begin
			a <= '{tgl: 1'b0, hold: INIT};
		end else begin
			a <= next_a;
		end
	end

	dclr_sync #(.W(1)) u_tsync (
		.clk_in  (clk_b_in),
		.rstn_in (rstn_b_in),
		.d_in    (a.tgl),
		.q_out   (tgl_b)
	);

	// receiver: copy the word once the toggle has settled
	always_comb begin
		next_b     = b;
		next_b.tq  = tgl_b;
		next_b.stb = 1'b0;
		if (tgl_b != b.tq) begin
			next_b.data = a.hold;
			next_b.stb  = 1'b1;
		end
	end

	always_ff @(posedge clk_b_in) begin
		if (!rstn_b_in) begin
			b <= '{tq: 1'b0, data: INIT, stb: 1'b0};
		end else begin
			b <= next_b;
		end
	end

	assign data_b_out = b.data;
	assign stb_b_out  = b.stb;
endmodule
